// ---- pkg/ext_mem_pkg.sv ----
package ext_mem_pkg;
	// register byte addresses (printed offsets are not all multiples of four: index*4)
	localparam logic [7:0] idx_config_one   = 8'hf5;
	localparam logic [7:0] idx_config_two   = 8'hf6;
	localparam logic [7:0] idx_wait_control = 8'hfc;
	localparam logic [7:0] idx_bus_control  = 8'hfd;
	localparam logic [11:0] addr_config_one   = {2'h0, idx_config_one, 2'h0};
	localparam logic [11:0] addr_config_two   = {2'h0, idx_config_two, 2'h0};
	localparam logic [11:0] addr_wait_control = {2'h0, idx_wait_control, 2'h0};
	localparam logic [11:0] addr_bus_control  = {2'h0, idx_bus_control, 2'h0};
	// reset values
	localparam logic [7:0] rst_config_one   = 8'h80;
	localparam logic [7:0] rst_config_two   = 8'h0f;
	localparam logic [7:0] rst_wait_control = 8'h7f;
	localparam logic [7:0] rst_bus_control  = 8'h00;
	// config one fields
	localparam int bit_strobe_mode    = 6;
	localparam int bit_second_strobe  = 5;
	localparam int bit_strobe_alt     = 4;
	localparam int bit_internal_tog   = 2;
	localparam int bit_drive_select   = 1;
	localparam logic [7:0] mask_config_one = 8'hf6;
	// config two fields
	localparam int bit_segment_save   = 6;
	localparam int bit_page_remap     = 5;
	localparam int bit_ext_mem_select = 4;
	localparam int lsb_lower_as       = 2;
	localparam int lsb_upper_as       = 0;
	localparam logic [7:0] mask_config_two = 8'h7f;
	// wait control fields
	localparam int bit_watchdog       = 6;
	localparam int lsb_upper_ds       = 3;
	localparam int lsb_lower_ds       = 0;
	localparam logic [7:0] mask_wait_control = 8'h7f;
	// bus control: bit0 hold input enable, bit1 low port alt, bit2 high port alt
	localparam int bit_hold_enable    = 0;
	localparam int bit_low_port_alt   = 1;
	localparam int bit_high_port_alt  = 2;
	localparam logic [7:0] mask_bus_control = 8'h07;
	localparam int addr_top_bit       = 21;
	typedef enum logic [2:0] {
		st_idle    = 3'b000,
		st_addr    = 3'b001,
		st_addr_x  = 3'b010,
		st_data    = 3'b011,
		st_data_x  = 3'b100
	} cyc_state_t;
endpackage

// ---- core/sync2.sv ----
`timescale 1ns/10ps
// two-stage synchroniser for a pin level
module sync2
(
	input  wire logic clk,     // clock
	input  wire logic rst_n,   // sync reset, active low
	input  wire logic d,       // async level
	output logic      q        // synchronised level
);
	logic meta;
	// reset high: the pin idles high under pull-up
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta <= 1'b1;
			q    <= 1'b1;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ---- core/external_memory_bus_interface.sv ----
`timescale 1ns/10ps
// Behaviour
// - cycle is address phase then data phase
// - low port multiplexes address low and data
// - high port drives address high all cycle
// - sample wait each phase when enabled
// - each low wait adds one cycle
// - wait stretches address or data strobe
// - wait pin bidirectional with pull-up in reset
// - strobe mode inverts address strobe to latch
// - strobe mode: data strobe is output enable
// - strobe mode: read/write becomes write enable
// - second strobe disabled: held high
// - second strobe serves lower block only
// - alt enable bit connects address strobe
// - toggle bit lets pins move internally
// - drive bit selects buffer strength
// - segment save off: push pc, flags only
// - segment save on: also push code segment
// - remap bit swaps page registers with ports
// - lower address strobe stretch, reset three
// - upper address strobe stretch, reset three
// - upper data strobe stretch, reset seven
// - lower data strobe stretch, reset seven
module external_memory_bus_interface
	import ext_mem_pkg::*;
(
	input  wire logic        clk,              // internal clock, 40 MHz
	input  wire logic        rst_n,            // sync reset, active low
	input  wire logic        psel,             // apb select
	input  wire logic        penable,          // apb enable
	input  wire logic        pwrite,           // apb direction
	input  wire logic [11:0] paddr,            // apb byte address
	input  wire logic [31:0] pwdata,           // apb write data
	output logic      [31:0] prdata,           // apb read data
	output logic             pready,           // apb ready
	output logic             pslverr,          // apb error
	input  wire logic        cyc_req,          // cpu memory request
	input  wire logic [21:0] cyc_addr,         // cpu internal address
	input  wire logic        cyc_write,        // cpu write
	input  wire logic        cyc_external,     // access goes off chip
	input  wire logic [7:0]  cyc_wdata,        // cpu write data
	output logic             cyc_ack,          // cycle done pulse
	output logic      [7:0]  cyc_rdata,        // read data
	output logic             cyc_busy,         // cycle in flight
	output logic             address_phase,    // in address phase
	output logic             data_phase,       // in data phase
	output logic      [7:0]  low_port_out,     // addr/data low byte out
	output logic      [7:0]  low_port_oe,      // low byte drive enables
	input  wire logic [7:0]  low_port_in,      // low byte pin levels
	output logic      [7:0]  high_port_out,    // address high byte
	output logic      [7:0]  high_port_oe,     // high byte drive enables
	output logic             address_strobe_n, // address strobe or latch enable
	output logic             address_strobe_oe,// address strobe drive enable
	output logic             data_strobe_n,    // data strobe or output enable
	output logic             second_data_strobe_n, // lower block strobe
	output logic             rw_n,             // read/write or write enable
	input  wire logic        hold_n_pin,       // wait pin level, active low
	output logic             hold_pin_pullup,  // weak pull-up on wait pin
	output logic             hold_pin_bidir,   // wait pin bidirectional mode
	output logic             output_drive_select, // strong buffers
	output logic             segment_save_enable, // to interrupt engine
	output logic             page_register_remap, // to page decode
	output logic             external_memory_select, // memory select
	output logic             watchdog_enable   // to timer
);
	logic [7:0]  config_one;
	logic [7:0]  config_two;
	logic [7:0]  wait_control;
	logic [7:0]  bus_control;
	logic        hold_n_sync;
	cyc_state_t  state;
	logic [2:0]  stretch_cnt;
	logic [21:0] lat_addr;
	logic        lat_write;
	logic        lat_ext;
	logic [7:0]  lat_wdata;
	logic        apb_write;
	logic        apb_hit;
	logic        upper_blk;
	logic        hold_active;
	logic        strobe_mode;
	logic        ds2_en;
	logic        pins_move;
	logic        as_raw_n;
	logic        ds_raw_n;
	logic        rw_level;
	logic        addr_done;
	logic        start_moves;

	sync2 u_hold_sync
	(
		.clk  (clk),
		.rst_n(rst_n),
		.d    (hold_n_pin),
		.q    (hold_n_sync)
	);

	// apb: zero-wait slave, unmapped gives error
	assign pready    = 1'b1;
	assign apb_write = psel && penable && pwrite;
	always_comb
	begin
		apb_hit = (paddr == addr_config_one) || (paddr == addr_config_two) ||
			(paddr == addr_wait_control) || (paddr == addr_bus_control);
	end
	assign pslverr = psel && penable && !apb_hit;

	// register writes
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			config_one   <= rst_config_one;
			config_two   <= rst_config_two;
			wait_control <= rst_wait_control;
			bus_control  <= rst_bus_control;
		end
		else if (apb_write)
		begin
			case (paddr)
				addr_config_one:   config_one   <= pwdata[7:0] & mask_config_one;
				addr_config_two:   config_two   <= pwdata[7:0] & mask_config_two;
				addr_wait_control: wait_control <= pwdata[7:0] & mask_wait_control;
				addr_bus_control:  bus_control  <= pwdata[7:0] & mask_bus_control;
				default:           config_one   <= config_one;
			endcase
		end
	end

	// read mux, registered
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				addr_config_one:   prdata <= {24'h0, config_one};
				addr_config_two:   prdata <= {24'h0, config_two};
				addr_wait_control: prdata <= {24'h0, wait_control};
				addr_bus_control:  prdata <= {24'h0, bus_control};
				default:           prdata <= 32'h0;
			endcase
		end
	end

	// static controls handed to other blocks
	assign output_drive_select    = config_one[bit_drive_select];
	assign segment_save_enable    = config_two[bit_segment_save];
	assign page_register_remap    = config_two[bit_page_remap];
	assign external_memory_select = config_two[bit_ext_mem_select];
	assign watchdog_enable        = wait_control[bit_watchdog];
	assign strobe_mode = config_one[bit_strobe_mode];
	assign ds2_en      = config_one[bit_second_strobe];
	// pin stays pulled up and bidirectional in reset and after
	assign hold_pin_pullup = 1'b1;
	assign hold_pin_bidir  = 1'b1;

	// wait only counts when enabled; otherwise stretches alone
	assign hold_active = bus_control[bit_hold_enable] && !hold_n_sync;
	assign upper_blk   = lat_addr[addr_top_bit];

	// cycle engine: address phase, data phase, each stretchable
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state       <= st_idle;
			stretch_cnt <= 3'h0;
			lat_addr    <= 22'h0;
			lat_write   <= 1'b0;
			lat_ext     <= 1'b0;
			lat_wdata   <= 8'h0;
		end
		else
		begin
			case (state)
				st_idle:
				begin
					if (cyc_req)
					begin
						state     <= st_addr;
						lat_addr  <= cyc_addr;
						lat_write <= cyc_write;
						lat_ext   <= cyc_external;
						lat_wdata <= cyc_wdata;
						stretch_cnt <= cyc_addr[addr_top_bit] ?
							{1'b0, config_two[lsb_upper_as +: 2]} :
							{1'b0, config_two[lsb_lower_as +: 2]};
					end
				end
				st_addr, st_addr_x:
				begin
					if (hold_active)
						state <= st_addr_x;
					else if (stretch_cnt != 3'h0)
					begin
						state       <= st_addr_x;
						stretch_cnt <= stretch_cnt - 3'h1;
					end
					else
					begin
						state       <= st_data;
						stretch_cnt <= upper_blk ? wait_control[lsb_upper_ds +: 3] :
							wait_control[lsb_lower_ds +: 3];
					end
				end
				st_data, st_data_x:
				begin
					if (hold_active)
						state <= st_data_x;
					else if (stretch_cnt != 3'h0)
					begin
						state       <= st_data_x;
						stretch_cnt <= stretch_cnt - 3'h1;
					end
					else
						state <= st_idle;
				end
				default: state <= st_idle;
			endcase
		end
	end

	assign address_phase = (state == st_addr) || (state == st_addr_x);
	assign data_phase    = (state == st_data) || (state == st_data_x);
	assign cyc_busy      = (state != st_idle);
	assign cyc_ack = data_phase && !hold_active && (stretch_cnt == 3'h0);

	// read data captured at end of data phase
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cyc_rdata <= 8'h0;
		else if (cyc_ack && !lat_write && lat_ext)
			cyc_rdata <= low_port_in;
	end

	// internal cycles move pins only with toggle bit set
	assign pins_move   = lat_ext || config_one[bit_internal_tog];
	assign start_moves = (state == st_idle) && cyc_req &&
		(cyc_external || config_one[bit_internal_tog]);
	assign addr_done   = address_phase && !hold_active && (stretch_cnt == 3'h0);

	// address goes out on the request edge: a later load would miss the strobe
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			low_port_out  <= 8'hff;
			high_port_out <= 8'hff;
			rw_level      <= 1'b1;
		end
		else if (start_moves)
		begin
			high_port_out <= cyc_addr[15:8];
			low_port_out  <= cyc_addr[7:0];
			rw_level      <= !cyc_write;
		end
		else if (addr_done && pins_move)
			low_port_out <= lat_wdata;
	end

	// classic: level over cycle; strobe mode: write enable in data strobe time
	assign rw_n = strobe_mode ? !(lat_write && lat_ext && data_phase) : rw_level;

	// low port floats during a read data phase so memory can drive it
	assign low_port_oe  = {8{bus_control[bit_low_port_alt] &&
		!(data_phase && !lat_write && pins_move)}};
	assign high_port_oe = {8{bus_control[bit_high_port_alt]}};

	// raw strobes, active low, classic timing
	assign as_raw_n = !(address_phase && pins_move);
	assign ds_raw_n = !(data_phase && lat_ext && !(strobe_mode && lat_write));
	// latch enable is the inverted strobe
	assign address_strobe_n  = strobe_mode ? !as_raw_n : as_raw_n;
	assign address_strobe_oe = config_one[bit_strobe_alt];
	// lower block routes to the second strobe when enabled
	assign data_strobe_n = (ds2_en && !upper_blk) ? 1'b1 : ds_raw_n;
	assign second_data_strobe_n = (ds2_en && !upper_blk) ? ds_raw_n : 1'b1;

	// checks
	property p_two_phase;
		@(posedge clk) disable iff (!rst_n)
		(state == st_idle && cyc_req) |=> address_phase;
	endproperty
	a_two_phase: assert property (p_two_phase) else $error("no address phase");

	property p_addr_then_data;
		@(posedge clk) disable iff (!rst_n)
		(address_phase && !hold_active && stretch_cnt == 3'h0) |=> (state == st_data);
	endproperty
	a_addr_then_data: assert property (p_addr_then_data) else $error("bad phase");

	property p_hold_stretches;
		@(posedge clk) disable iff (!rst_n)
		(data_phase && hold_active) |=> data_phase;
	endproperty
	a_hold_stretches: assert property (p_hold_stretches) else $error("wait lost");

	property p_hold_as;
		@(posedge clk) disable iff (!rst_n)
		(address_phase && hold_active) |=> address_phase;
	endproperty
	a_hold_as: assert property (p_hold_as) else $error("as not stretched");

	property p_ds2_off;
		@(posedge clk) disable iff (!rst_n)
		!ds2_en |-> second_data_strobe_n;
	endproperty
	a_ds2_off: assert property (p_ds2_off) else $error("second strobe active");

	property p_oe_write;
		@(posedge clk) disable iff (!rst_n)
		(strobe_mode && lat_write) |-> (ds_raw_n && data_strobe_n);
	endproperty
	a_oe_write: assert property (p_oe_write) else $error("oe on write");

	property p_lower_as_stretch;
		@(posedge clk) disable iff (!rst_n)
		(state == st_idle && cyc_req && !cyc_addr[addr_top_bit] &&
			config_two[3:2] == 2'h3 && !bus_control[bit_hold_enable])
		|=> address_phase [*4] ##1 data_phase;
	endproperty
	a_lower_as_stretch: assert property (p_lower_as_stretch) else $error("as stretch");

	property p_internal_quiet;
		@(posedge clk) disable iff (!rst_n)
		(cyc_busy && !lat_ext) |-> (data_strobe_n && second_data_strobe_n);
	endproperty
	a_internal_quiet: assert property (p_internal_quiet) else $error("ds internal");

	property p_addr_on_pins;
		@(posedge clk) disable iff (!rst_n)
		(address_phase && pins_move) |-> ({high_port_out, low_port_out} == lat_addr[15:0]);
	endproperty
	a_addr_on_pins: assert property (p_addr_on_pins) else $error("address not on pins");

	property p_write_enable;
		@(posedge clk) disable iff (!rst_n)
		(strobe_mode && data_phase && lat_ext) |-> (rw_n == !lat_write);
	endproperty
	a_write_enable: assert property (p_write_enable) else $error("write enable timing");

	c_ext_read:  cover property (@(posedge clk) disable iff (!rst_n)
		cyc_ack && lat_ext && !lat_write);
	c_ext_write: cover property (@(posedge clk) disable iff (!rst_n)
		cyc_ack && lat_ext && lat_write);
	c_hold:      cover property (@(posedge clk) disable iff (!rst_n)
		data_phase && hold_active);
endmodule

// ---- dv/ext_mem_model.sv ----
`timescale 1ns/10ps
// external rom/ram seen at the pins; the read byte is a pattern of the address until that byte is written
module ext_mem_model
(
	input  wire logic        clk,    // internal clock
	input  wire logic        mode,   // latch-enable strobe style in use
	input  wire logic [1:0]  stall,  // wait cycles asked per access
	input  wire logic        as_n,   // address strobe pin
	input  wire logic        ds_n,   // data strobe pin
	input  wire logic        ds2_n,  // second data strobe pin
	input  wire logic        rw_n,   // read/write pin
	input  wire logic [7:0]  lo_out, // low byte from device
	input  wire logic [7:0]  lo_oe,  // low byte enables
	input  wire logic [7:0]  hi_out, // high address byte
	output logic      [7:0]  lo_in,  // resolved low byte
	output logic             hold_n, // wait pin, pulled up when idle
	output logic      [15:0] addr    // latched address
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	logic [2:0] hcnt = 3'h7;
	logic       was_on = 1'b0;
	logic       as_on;
	logic       rd_on;
	initial
	begin
		for (int a = 0; a < 65536; a++)
			mem[a] = a[7:0] ^ a[15:8] ^ 8'h5a;
	end
	// ale is high-active, classic strobe low-active
	assign as_on = mode ? as_n : !as_n;
	assign rd_on = (!ds_n || !ds2_n) && rw_n;
	// released lines show the inverse of the last value so stale data never passes
	assign lo_in = (lo_oe & lo_out) | (~lo_oe & (rd_on ? mem[addr] : ~last));
	// wait held low for stall cycles from each address strobe start
	assign hold_n = !(hcnt < {1'b0, stall});
	always @(posedge clk)
	begin
		was_on <= as_on;
		last <= lo_in;
		if (as_on)
			addr <= {hi_out, lo_out};
		if (as_on && !was_on)
			hcnt <= 3'h0;
		else if (hcnt != 3'h7)
			hcnt <= hcnt + 3'h1;
		if (mode ? !rw_n : (!rw_n && (!ds_n || !ds2_n)))
			mem[addr] <= lo_out;
	end
endmodule

// ---- dv/test_external_memory_bus_interface.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module test_external_memory_bus_interface;
	import ext_mem_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, cyc_ack, cyc_busy, address_phase, data_phase;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        cyc_req = 1'b0, cyc_write = 1'b0, cyc_external = 1'b0, mode = 1'b0;
	logic [21:0] cyc_addr = '0;
	logic [7:0]  cyc_wdata = '0, cyc_rdata, low_port_out, low_port_oe, low_port_in;
	logic [7:0]  high_port_out, high_port_oe, c1, c2, wc;
	logic        address_strobe_n, address_strobe_oe, data_strobe_n, second_data_strobe_n;
	logic        rw_n, hold_n_pin, hold_pin_pullup, hold_pin_bidir, output_drive_select;
	logic        segment_save_enable, page_register_remap, external_memory_select;
	logic        watchdog_enable;
	logic [1:0]  stall = 2'h0;
	logic [15:0] m_addr;
	logic [7:0]  ref_m [0:65535];
	int          miscompares = 0, n_tests = 0, cycles = 0, as_cnt, ds_cnt, ds2_cnt;

	external_memory_bus_interface dut (.*);
	ext_mem_model mem (.clk(clk), .mode(mode), .stall(stall), .as_n(address_strobe_n),
		.ds_n(data_strobe_n), .ds2_n(second_data_strobe_n), .rw_n(rw_n),
		.lo_out(low_port_out), .lo_oe(low_port_oe), .hi_out(high_port_out),
		.lo_in(low_port_in), .hold_n(hold_n_pin), .addr(m_addr));

	initial
	begin
		forever #12.5 clk = !clk;
	end
	// strobe activity counted mid-cycle, away from the launching edge
	always @(negedge clk)
	begin
		as_cnt = as_cnt + ((address_strobe_n === mode) ? 1 : 0);
		ds_cnt = ds_cnt + ((data_strobe_n === 1'b0) ? 1 : 0);
		ds2_cnt = ds2_cnt + ((second_data_strobe_n === 1'b0) ? 1 : 0);
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// a hang is cut short well beyond the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	function automatic logic [7:0] blank(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] ex);
		logic [7:0] q;
		logic e;
		apb(1'b0, a, 8'h00, q, e);
		`CHK(q, ex)
	endtask
	// one memory cycle; external ones checked for length, address and data, and for strobes
	// unless a wait is asked with the hold enable set; internal ones for strobes only
	task automatic run(input logic [21:0] a, input logic w, x, input logic [7:0] d,
		input logic hen);
		int lat, ex;
		logic [1:0] as_x;
		logic [2:0] ds_x;
		logic lo2, off, rwa;
		as_x = a[21] ? c2[1:0] : c2[3:2];
		ds_x = a[21] ? wc[5:3] : wc[2:0];
		lo2 = c1[5] && !a[21];
		off = mode && w;
		ex = as_x + ds_x + 2;
		lat = 0;
		as_cnt = 0;
		ds_cnt = 0;
		ds2_cnt = 0;
		cyc_req <= 1'b1;
		cyc_addr <= a;
		cyc_write <= w;
		cyc_external <= x;
		cyc_wdata <= d;
		@(posedge clk);
		cyc_req <= 1'b0;
		do
		begin
			@(negedge clk);
			lat++;
			rwa = rw_n;
		end
		while (cyc_ack !== 1'b1 && lat < 100);
		`CHK({cyc_busy, data_phase, address_phase}, 3'b110)
		`CHK({high_port_oe, low_port_oe}, {8'hff, (w || !(x || c1[2])) ? 8'hff : 8'h00})
		@(posedge clk);
		@(negedge clk);
		if (!x)
		begin
			`CHK(ds_cnt + ds2_cnt, 0)
			if (!c1[2]) `CHK(as_cnt, 0)
		end
		else
		begin
			if (hen && stall != 2'h0)
				`CHK(lat >= ex && lat <= ex + stall + 3, 1'b1)
			else
			begin
				`CHK(lat, ex)
				`CHK(as_cnt, 1 + as_x)
				`CHK(ds_cnt, (lo2 || off) ? 0 : ds_x + 1)
				`CHK(ds2_cnt, (!lo2 || off) ? 0 : ds_x + 1)
			end
			`CHK(rwa, !w)
			`CHK(m_addr, a[15:0])
			if (!w) `CHK(cyc_rdata, ref_m[a[15:0]])
			else ref_m[a[15:0]] = d;
		end
		@(posedge clk);
	endtask

	initial
	begin
		logic [7:0] q;
		logic e, x, w, hen;
		logic [21:0] a;
		void'($urandom(32'hda77e085));
		for (int i = 0; i < 65536; i++)
			ref_m[i] = blank(16'(i));
		repeat (5) @(posedge clk);
		`CHK(hold_pin_pullup & hold_pin_bidir, 1'b1)
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(addr_config_one, 8'h80);
		rchk(addr_config_two, 8'h0f);
		rchk(addr_wait_control, 8'h7f);
		wr(addr_config_one, 8'hff);
		rchk(addr_config_one, 8'hf6);
		wr(addr_wait_control, 8'hff);
		rchk(addr_wait_control, 8'h7f);
		apb(1'b1, 12'h000, 8'hff, q, e);
		apb(1'b0, 12'h000, 8'h00, q, e);
		`CHK({e, q}, 9'h100)
		$display("test registers done");
		for (int i = 0; i < 24; i++)
		begin
			c1 = 8'($urandom) & 8'hf6;
			c2 = {1'b0, 2'($urandom), 1'b1, 4'($urandom)};
			wc = {2'b01, 6'($urandom)};
			// first two passes pin the stretch fields to zero and to maximum
			if (i < 2)
			begin
				c2[3:0] = (i == 0) ? 4'h0 : 4'hf;
				wc[5:0] = (i == 0) ? 6'h00 : 6'h3f;
			end
			a = 22'($urandom) & 22'h200303;
			x = (i % 5 != 4);
			w = x && 1'($urandom);
			hen = 1'($urandom);
			stall <= 2'($urandom);
			mode <= c1[6];
			wr(addr_config_one, c1);
			wr(addr_config_two, c2);
			wr(addr_wait_control, wc);
			wr(addr_bus_control, {5'h0, 2'b11, hen});
			`CHK({output_drive_select, segment_save_enable}, {c1[1], c2[6]})
			`CHK({page_register_remap, watchdog_enable}, {c2[5], wc[6]})
			`CHK({address_strobe_oe, external_memory_select}, {c1[4], 1'b1})
			run(a, w, x, 8'($urandom), hen);
			$display("test cycle %0d done", i);
		end
		wrap_up();
	end
endmodule
